// >>> verilog/cid_pkg.sv
// constants, opcodes, register map and state codes of the instruction decoder
package cid_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses on the wishbone bus)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_WORKING    = 8'h04;
	localparam logic [7:0] OFS_BANK_SEL   = 8'h08;
	localparam logic [7:0] OFS_TBL_PTR    = 8'h0C;
	localparam logic [7:0] OFS_TBL_LATCH  = 8'h10;
	localparam logic [7:0] OFS_INDEX_BASE = 8'h14;
	localparam logic [7:0] OFS_DEC_STAT   = 8'h18;
	localparam logic [7:0] OFS_HOLD_BASE  = 8'h20;
	localparam logic [7:0] OFS_HOLD_LAST  = 8'h3C;

	// field positions and reset values
	localparam int         CTRL_EXT_EN_BIT = 0;
	localparam logic [0:0] CTRL_RESET      = 1'h0;
	localparam logic [7:0] WORKING_RESET   = 8'h00;
	localparam logic [5:0] BANK_SEL_RESET  = 6'h00;
	localparam logic [20:0] TBL_PTR_RESET  = 21'h000000;
	localparam logic [7:0] TBL_LATCH_RESET = 8'h00;
	localparam logic [13:0] INDEX_RESET    = 14'h0000;
	localparam logic [7:0] HOLD_RESET      = 8'hFF;

	// widths and address space
	localparam int         PC_W         = 21;
	localparam int         FILE_W       = 14;
	localparam int         HOLD_N       = 8;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;  // access bank low part is 00h..5Fh
	localparam logic [7:0] INDEX_MAX    = 8'h5F;
	localparam logic [5:0] ACCESS_HI_BANK = 6'h3F;
	localparam logic [1:0] RESTRICT_BANK  = 2'h0;

	// opcode patterns
	localparam logic [3:0]  OP_SECOND  = 4'hF;
	localparam logic [4:0]  OP_BCC     = 5'h1C;
	localparam logic [4:0]  OP_BRANCH   = 5'h1A;
	localparam logic [4:0]  OP_REL_CALL = 5'h1B;
	localparam logic [6:0]  OP_CALL    = 7'h76;
	localparam logic [7:0]  OP_GOTO    = 8'hEF;
	localparam logic [3:0]  OP_MOVE    = 4'hC;
	localparam logic [5:0]  OP_SWAP    = 6'h0E;
	localparam logic [7:0]  OP_RETLIT  = 8'h0C;
	localparam logic [14:0] OP_RETINT  = 15'h0008;
	localparam logic [14:0] OP_RETURN  = 15'h0009;
	localparam logic [15:0] OP_CALL_WORKING = 16'h0014;
	localparam logic [15:0] OP_POP     = 16'h0006;
	localparam logic [15:0] OP_PUSH    = 16'h0005;
	localparam logic [15:0] OP_SLEEP   = 16'h0003;
	localparam logic [15:0] OP_RESET   = 16'h00FF;
	localparam logic [13:0] OP_TABLE_WRITE = 14'h0003;

	// table write pointer modes
	localparam logic [1:0] TW_KEEP = 2'h0;
	localparam logic [1:0] TW_POST_INC = 2'h1;
	localparam logic [1:0] TW_POST_DEC = 2'h2;
	localparam logic [1:0] TW_PRE_INC  = 2'h3;

	// decoder states
	typedef enum logic [4:0] {
		CID_RUN    = 5'h01,
		CID_SECOND = 5'h02,
		CID_FLUSH  = 5'h04,
		CID_EXTRA  = 5'h08,
		CID_SLEEP  = 5'h10
	} cid_state_t;

endpackage

// >>> verilog/cid_decoder.sv
// instruction decoder for control, inherent, swap and table-write instructions
// What this block does
// - pc change or true condition costs one extra cycle, run as no-operation
// - second words decode as no-operation unless consumed; 1111xxxx words are no-ops
// - restricted move operands get bank bits forced to 00, lower 4k only
// - nibble swap 0011 10da ffff ffff exchanges nibbles in one cycle
// - swap d=0 writes working register, d=1 writes the file register
// - swap a=0 resolves the address into the access bank
// - swap a=1 takes the bank from the bank select register
// - a=0, extended set on, f up to 95: indexed literal offset addressing
// - table write picks one of eight holding registers by pointer bits 2:0
// - table pointer is a 21-bit byte address over 2 MB
// - pointer bit 0 picks low (0) or high (1) byte of a word
// - table write mode: keep, post-inc, post-dec, pre-inc; two cycles
// - holding registers stage data for program memory writes
// - call is two words, 1110 110s + 8 bits then 1111 + 12 bits
// - goto is two words, 1110 1111 + 8 bits then 1111 + 12 bits
// - 0014h loads working register into pc low byte and calls
// - 0010h/0011h return and enable interrupts; 0012h/0013h return; bit 0 shadow
// - 0Ckk puts literal into working register and returns
// - 0006h pops, 0005h pushes the return stack, one cycle, no flags
// - 1110 0ccc conditional branches, 1101 0 unconditional 11-bit branch
// - 0003h enters standby, 00FFh requests a software reset
`timescale 1ns/1ps
module cid_decoder (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// instruction stream from fetch
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [20:0] instr_pc,
	input  wire logic [7:0]  file_rdata,
	input  wire logic        flag_z,
	input  wire logic        flag_c,
	input  wire logic        flag_ov,
	input  wire logic        flag_n,
	input  wire logic        wake_evt,
	// control towards the datapath
	output logic             fetch_hold,
	output logic             pc_load,
	output logic [20:0]      pc_target,
	output logic             pc_from_stack,
	output logic             stack_push,
	output logic [20:0]      stack_push_value,
	output logic             stack_pop,
	output logic             shadow_save,
	output logic             shadow_restore,
	output logic             int_enable_set,
	output logic             sleep_req,
	output logic             soft_reset_req,
	output logic             file_we,
	output logic [13:0]      file_addr,
	output logic [7:0]       file_wdata,
	output logic             indexed_mode,
	output logic             move_req,
	output logic [13:0]      move_src,
	output logic [13:0]      move_dst,
	output logic [63:0]      hold_bytes,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// byte-lane merge of a bus write into a 32-bit image
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// branch target: pc of the next word plus twice the signed word offset
	function automatic logic [20:0] rel_target(input logic [20:0] pc,
		input logic [20:0] ofs);
		return pc + 21'h000002 + {ofs[19:0], 1'b0};
	endfunction

	// ------------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------------
	cid_pkg::cid_state_t state;
	logic        ext_en;
	logic [7:0]  working_register;
	logic [5:0]  bank_select_register;
	logic [20:0] table_pointer;
	logic [7:0]  table_latch;
	logic [13:0] index_base;
	logic [7:0]  hold_reg [cid_pkg::HOLD_N];
	logic [7:0]  first_low;        // low address byte of the pending first word
	logic        first_is_call;
	logic        first_shadow;
	logic [11:0] move_first;       // source operand of a pending move
	logic        first_is_move;
	logic [20:0] first_pc;

	// ------------------------------------------------------------------
	// decode of the presented word
	// ------------------------------------------------------------------
	logic        take_first;
	logic        take_second;
	logic [15:0] w;
	logic        is_bcc, is_branch, is_rel_call, is_call, is_goto, is_move, is_swap;
	logic        is_retlit, is_retint, is_return, is_call_working, is_pop, is_push;
	logic        is_sleep, is_reset, is_table_write, cond_true;
	logic [13:0] swap_addr;
	logic        swap_indexed;
	logic [7:0]  swap_result;
	logic [20:0] tw_ptr_used;
	logic [20:0] next_table_pointer;

	assign w           = instr_word;
	assign take_first  = instr_valid && (state == cid_pkg::CID_RUN);
	assign take_second = instr_valid && (state == cid_pkg::CID_SECOND);

	// a 1111 word met directly falls through every compare and is a no-op
	always_comb begin
		is_bcc    = (w[15:11] == cid_pkg::OP_BCC);
		is_branch   = (w[15:11] == cid_pkg::OP_BRANCH);
		is_rel_call = (w[15:11] == cid_pkg::OP_REL_CALL);
		is_call   = (w[15:9] == cid_pkg::OP_CALL);
		is_goto   = (w[15:8] == cid_pkg::OP_GOTO);
		is_move   = (w[15:12] == cid_pkg::OP_MOVE);
		is_swap   = (w[15:10] == cid_pkg::OP_SWAP);
		is_retlit = (w[15:8] == cid_pkg::OP_RETLIT);
		is_retint = (w[15:1] == cid_pkg::OP_RETINT);
		is_return = (w[15:1] == cid_pkg::OP_RETURN);
		is_call_working = (w == cid_pkg::OP_CALL_WORKING);
		is_pop    = (w == cid_pkg::OP_POP);
		is_push   = (w == cid_pkg::OP_PUSH);
		is_sleep  = (w == cid_pkg::OP_SLEEP);
		is_reset  = (w == cid_pkg::OP_RESET);
		is_table_write = (w[15:2] == cid_pkg::OP_TABLE_WRITE);
	end

	// condition codes of the short branches
	always_comb begin
		case (w[10:8])
			3'h0:    cond_true = flag_z;
			3'h1:    cond_true = !flag_z;
			3'h2:    cond_true = flag_c;
			3'h3:    cond_true = !flag_c;
			3'h4:    cond_true = flag_ov;
			3'h5:    cond_true = !flag_ov;
			3'h6:    cond_true = flag_n;
			default: cond_true = !flag_n;
		endcase
	end

	// swap operand address: indexed, access bank or banked
	always_comb begin
		swap_indexed = 1'b0;
		if (!w[8] && ext_en && (w[7:0] <= cid_pkg::INDEX_MAX)) begin
			swap_indexed = 1'b1;
			swap_addr    = index_base + {6'h00, w[7:0]};
		end else if (!w[8]) begin
			if (w[7:0] < cid_pkg::ACCESS_SPLIT) begin
				swap_addr = {6'h00, w[7:0]};
			end else begin
				swap_addr = {cid_pkg::ACCESS_HI_BANK, w[7:0]};
			end
		end else begin
			swap_addr = {bank_select_register, w[7:0]};
		end
		swap_result = {file_rdata[3:0], file_rdata[7:4]};
	end

	// table pointer before and after a table write
	always_comb begin
		tw_ptr_used        = table_pointer;
		next_table_pointer = table_pointer;
		case (w[1:0])
			cid_pkg::TW_POST_INC: next_table_pointer = table_pointer + 21'h000001;
			cid_pkg::TW_POST_DEC: next_table_pointer = table_pointer - 21'h000001;
			cid_pkg::TW_PRE_INC: begin
				tw_ptr_used        = table_pointer + 21'h000001;
				next_table_pointer = tw_ptr_used;
			end
			default: next_table_pointer = table_pointer;       // keep
		endcase
	end

	// ------------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------------

	// state walk; a pc change parks in flush so the prefetched word dies
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= cid_pkg::CID_RUN;
		end else begin
			case (state)
				cid_pkg::CID_RUN: begin
					if (take_first) begin
						if (is_call || is_goto || is_move) begin
							state <= cid_pkg::CID_SECOND;
						end else if ((is_bcc && cond_true) || is_branch || is_rel_call ||
							is_call_working || is_retint || is_return || is_retlit) begin
							state <= cid_pkg::CID_FLUSH;
						end else if (is_table_write) begin
							state <= cid_pkg::CID_EXTRA;
						end else if (is_sleep) begin
							state <= cid_pkg::CID_SLEEP;
						end
					end
				end
				cid_pkg::CID_SECOND: begin
					if (take_second) begin
						state <= first_is_move ? cid_pkg::CID_RUN : cid_pkg::CID_FLUSH;
					end
				end
				cid_pkg::CID_FLUSH: begin
					if (instr_valid) begin
						state <= cid_pkg::CID_RUN;
					end
				end
				cid_pkg::CID_EXTRA: state <= cid_pkg::CID_RUN;
				cid_pkg::CID_SLEEP: begin
					if (wake_evt) begin
						state <= cid_pkg::CID_RUN;
					end
				end
				default: state <= cid_pkg::CID_RUN;
			endcase
		end
	end

	// first word of a two-word instruction, kept for its second word
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_low     <= 8'h00;
			first_is_call <= 1'b0;
			first_shadow  <= 1'b0;
			first_is_move <= 1'b0;
			move_first    <= 12'h000;
			first_pc      <= 21'h000000;
		end else if (take_first && (is_call || is_goto || is_move)) begin
			first_low     <= w[7:0];
			first_is_call <= is_call;
			first_shadow  <= w[8];
			first_is_move <= is_move;
			move_first    <= w[11:0];
			first_pc      <= instr_pc;
		end
	end

	// flow control pulses towards pc and return stack
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load          <= 1'b0;
			pc_target        <= 21'h000000;
			pc_from_stack    <= 1'b0;
			stack_push       <= 1'b0;
			stack_push_value <= 21'h000000;
			stack_pop        <= 1'b0;
			shadow_save      <= 1'b0;
			shadow_restore   <= 1'b0;
			int_enable_set   <= 1'b0;
			soft_reset_req   <= 1'b0;
		end else begin
			pc_load        <= 1'b0;
			pc_from_stack  <= 1'b0;
			stack_push     <= 1'b0;
			stack_pop      <= 1'b0;
			shadow_save    <= 1'b0;
			shadow_restore <= 1'b0;
			int_enable_set <= 1'b0;
			soft_reset_req <= 1'b0;
			if (take_first) begin
				if (is_bcc && cond_true) begin
					pc_load   <= 1'b1;
					pc_target <= rel_target(instr_pc, {{13{w[7]}}, w[7:0]});
				end else if (is_branch || is_rel_call) begin
					pc_load   <= 1'b1;
					pc_target <= rel_target(instr_pc, {{10{w[10]}}, w[10:0]});
					stack_push       <= is_rel_call;
					stack_push_value <= instr_pc + 21'h000002;
				end else if (is_call_working) begin
					pc_load          <= 1'b1;
					pc_target        <= {instr_pc[20:8], working_register};
					stack_push       <= 1'b1;
					stack_push_value <= instr_pc + 21'h000002;
				end else if (is_retint || is_return || is_retlit) begin
					pc_from_stack  <= 1'b1;
					stack_pop      <= 1'b1;
					shadow_restore <= (is_retint || is_return) && w[0];
					int_enable_set <= is_retint;
				end else if (is_pop) begin
					stack_pop <= 1'b1;
				end else if (is_push) begin
					stack_push       <= 1'b1;
					stack_push_value <= instr_pc + 21'h000002;
				end else if (is_reset) begin
					soft_reset_req <= 1'b1;
				end
			end else if (take_second && !first_is_move) begin
				pc_load          <= 1'b1;
				pc_target        <= {w[11:0], first_low, 1'b0};
				stack_push       <= first_is_call;
				stack_push_value <= first_pc + 21'h000004;
				shadow_save      <= first_is_call && first_shadow;
			end
		end
	end

	// file register traffic of swap and move
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			file_we      <= 1'b0;
			file_addr    <= 14'h0000;
			file_wdata   <= 8'h00;
			indexed_mode <= 1'b0;
			move_req     <= 1'b0;
			move_src     <= 14'h0000;
			move_dst     <= 14'h0000;
		end else begin
			file_we  <= 1'b0;
			move_req <= 1'b0;
			if (take_first && is_swap) begin
				file_we      <= w[9];
				file_addr    <= swap_addr;
				file_wdata   <= swap_result;
				indexed_mode <= swap_indexed;
			end else if (take_second && first_is_move) begin
				move_req <= 1'b1;
				move_src <= {cid_pkg::RESTRICT_BANK, move_first};
				move_dst <= {cid_pkg::RESTRICT_BANK, w[11:0]};
			end
		end
	end

	// standby and fetch stall levels
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_req  <= 1'b0;
			fetch_hold <= 1'b0;
		end else begin
			sleep_req  <= (take_first && is_sleep) ||
				((state == cid_pkg::CID_SLEEP) && !wake_evt);
			fetch_hold <= take_first && is_table_write;
		end
	end

	// ------------------------------------------------------------------
	// registers shared by software and the decoder
	// ------------------------------------------------------------------
	logic        bus_wr;
	logic [31:0] wr_img;
	logic [31:0] rd_img;

	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

	// read image of the addressed word; unmapped words read zero
	always_comb begin
		rd_img = 32'h00000000;
		case (wb_adr_i)
			cid_pkg::OFS_CTRL:       rd_img = {31'h00000000, ext_en};
			cid_pkg::OFS_WORKING:    rd_img = {24'h000000, working_register};
			cid_pkg::OFS_BANK_SEL:   rd_img = {26'h0000000, bank_select_register};
			cid_pkg::OFS_TBL_PTR:    rd_img = {11'h000, table_pointer};
			cid_pkg::OFS_TBL_LATCH:  rd_img = {24'h000000, table_latch};
			cid_pkg::OFS_INDEX_BASE: rd_img = {18'h00000, index_base};
			cid_pkg::OFS_DEC_STAT:   rd_img = {27'h0000000, state};
			default: begin
				if ((wb_adr_i >= cid_pkg::OFS_HOLD_BASE) &&
					(wb_adr_i <= cid_pkg::OFS_HOLD_LAST)) begin
					rd_img = {24'h000000, hold_reg[wb_adr_i[4:2]]};
				end
			end
		endcase
		wr_img = lane_merge(rd_img, wb_dat_i, wb_sel_i);
	end

	// bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_img;
		end
	end

	// software-only controls
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_en               <= cid_pkg::CTRL_RESET[0];
			bank_select_register <= cid_pkg::BANK_SEL_RESET;
			table_latch          <= cid_pkg::TBL_LATCH_RESET;
			index_base           <= cid_pkg::INDEX_RESET;
		end else if (bus_wr) begin
			case (wb_adr_i)
				cid_pkg::OFS_CTRL:       ext_en <= wr_img[cid_pkg::CTRL_EXT_EN_BIT];
				cid_pkg::OFS_BANK_SEL:   bank_select_register <= wr_img[5:0];
				cid_pkg::OFS_TBL_LATCH:  table_latch <= wr_img[7:0];
				cid_pkg::OFS_INDEX_BASE: index_base <= wr_img[13:0];
				default: ;
			endcase
		end
	end

	// working register; the decoder's update wins over a bus write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			working_register <= cid_pkg::WORKING_RESET;
		end else if (take_first && is_retlit) begin
			working_register <= w[7:0];
		end else if (take_first && is_swap && !w[9]) begin
			working_register <= swap_result;
		end else if (bus_wr && (wb_adr_i == cid_pkg::OFS_WORKING)) begin
			working_register <= wr_img[7:0];
		end
	end

	// 21-bit table pointer; pre/post modes applied by the table write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer <= cid_pkg::TBL_PTR_RESET;
		end else if (take_first && is_table_write) begin
			table_pointer <= next_table_pointer;
		end else if (bus_wr && (wb_adr_i == cid_pkg::OFS_TBL_PTR)) begin
			table_pointer <= wr_img[20:0];
		end
	end

	// holding registers; bit 0 of the index is the low/high byte of a word
	for (genvar i = 0; i < cid_pkg::HOLD_N; i++) begin : g_hold
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				hold_reg[i] <= cid_pkg::HOLD_RESET;
			end else if (take_first && is_table_write && (tw_ptr_used[2:0] == 3'(i))) begin
				hold_reg[i] <= table_latch;
			end
		end
		// staging image for the program memory writer
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				hold_bytes[i*8 +: 8] <= cid_pkg::HOLD_RESET;
			end else begin
				hold_bytes[i*8 +: 8] <= hold_reg[i];
			end
		end
	end

endmodule

// >>> dv/cid_decoder_sva.sv
// assertion checker bound to the instruction decoder
`timescale 1ns/1ps
module cid_decoder_sva (
	input wire logic		ref_clk,
	input wire logic		rst_n,
	input wire logic		wake_evt,
	input wire logic		fetch_hold,
	input wire logic		pc_load,
	input wire logic		pc_from_stack,
	input wire logic		stack_push,
	input wire logic		stack_pop,
	input wire logic		shadow_save,
	input wire logic		shadow_restore,
	input wire logic		int_enable_set,
	input wire logic		sleep_req,
	input wire logic		file_we,
	input wire logic		move_req,
	input wire logic [13:0]	move_src,
	input wire logic [13:0]	move_dst,
	input wire logic		wb_cyc_i,
	input wire logic		wb_stb_i,
	input wire logic		wb_ack_o
);
	// ------------------------------------------------------------------
	// port relations, single core clock domain
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// the slot after a pc change carries no effect of the dropped word
	property p_flush;
		(pc_load || pc_from_stack) |=> !(pc_load || pc_from_stack || stack_push || stack_pop
			|| file_we || move_req);
	endproperty
	a_flush: assert property (p_flush) else $error("word behind pc change took effect");
	property p_extra;
		fetch_hold |=> !fetch_hold;
	endproperty
	a_extra: assert property (p_extra) else $error("table write extra cycle too long");
	property p_restore;
		(shadow_restore || int_enable_set) |-> pc_from_stack;
	endproperty
	a_restore: assert property (p_restore) else $error("restore without return");
	property p_save;
		shadow_save |-> stack_push && pc_load;
	endproperty
	a_save: assert property (p_save) else $error("shadow save without call");
	property p_bank;
		move_req |-> move_src[13:12] == 2'h0 && move_dst[13:12] == 2'h0;
	endproperty
	a_bank: assert property (p_bank) else $error("move bank bits not forced low");
	// standby holds until a wake event, then ends within two cycles
	property p_sleep;
		sleep_req && !wake_evt |=> sleep_req;
	endproperty
	a_sleep: assert property (p_sleep) else $error("standby left without wake");
	property p_wake;
		sleep_req && wake_evt |-> ##[1:2] !sleep_req;
	endproperty
	a_wake: assert property (p_wake) else $error("standby not left on wake");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus request not acknowledged");
endmodule

bind cid_decoder cid_decoder_sva chk_u (.ref_clk, .rst_n, .wake_evt, .fetch_hold, .pc_load,
	.pc_from_stack, .stack_push, .stack_pop, .shadow_save, .shadow_restore, .int_enable_set,
	.sleep_req, .file_we, .move_req, .move_src, .move_dst, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// >>> dv/cpu_instruction_decoder_tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module cpu_instruction_decoder_tb;
	logic		ref_clk, rst_n, instr_valid, wake_evt, fl, flag_z, flag_c, flag_ov, flag_n;
	logic		wb_cyc_i, wb_stb_i, wb_we_i, fetch_hold, pc_load, pc_from_stack, stack_push;
	logic		stack_pop, shadow_save, shadow_restore, int_enable_set, sleep_req;
	logic		soft_reset_req, file_we, indexed_mode, move_req, wb_ack_o;
	logic [15:0]	instr_word;
	logic [20:0]	instr_pc, pc_target, stack_push_value, ptr;
	logic [7:0]	file_rdata, wb_adr_i, file_wdata;
	logic [3:0]	wb_sel_i;
	logic [31:0]	wb_dat_i, wb_dat_o, rd;
	logic [13:0]	file_addr, move_src, move_dst;
	logic [63:0]	hold_bytes;
	int		num_errors = 0;
	int		n_compared = 0;
	int		idx;
	// all control pulses in one vector, pc_load on top, fetch_hold at bit 0
	wire logic [10:0]	pv = {pc_load, stack_push, stack_pop, pc_from_stack, shadow_save,
		shadow_restore, int_enable_set, soft_reset_req, file_we, move_req, fetch_hold};

	cid_decoder dut_u (.*);

	// ------------------------------------------------------------------
	// clock, tasks and sequence
	// ------------------------------------------------------------------
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// classic cycle; bounded wait since a dead slave would hang the run
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (wb_ack_o !== 1'h1 && i < 20);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		if (wb_ack_o !== 1'h1) begin
			num_errors++;
			print_verdict();
		end
	endtask

	// one word, pulses checked; a pc change is followed by a push that must vanish
	task automatic op(input logic [15:0] w, input logic [10:0] e);
		for (int j = 0; j < 2; j++) begin
			@(posedge ref_clk);
			{instr_valid, instr_word, instr_pc} <= {1'h1, j ? 16'h0005 : w, 21'h000200};
			{flag_z, flag_c, flag_ov, flag_n} <= {4{fl}};
			@(posedge ref_clk);
			instr_valid <= 1'h0;
			#1;
			chk(pv, j ? 11'h0 : e);
			if (!(e[10] | e[7])) break;
		end
	endtask

	// main sequence; flags all equal, so each condition is set true or false in turn
	initial begin
		{rst_n, instr_valid, wake_evt, fl, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h0;
		{instr_word, instr_pc, wb_adr_i, wb_dat_i, wb_sel_i, file_rdata} = {77'h0, 4'hF, 8'h53};
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		wb(0, cid_pkg::OFS_DEC_STAT, 0);
		chk(rd, 32'h01);
		for (int k = 0; k < 16; k++) begin
			fl = k[3] ^ k[0];
			op({5'h1C, k[2:0], 8'h04}, {k[3], 10'h0});
			if (k[3]) chk(pc_target, 21'h00020A);
		end
		op(16'hD7FF, 11'h400);
		chk(pc_target, 21'h000200);
		op(16'hDFFF, 11'h600);
		chk({pc_target, stack_push_value}, {21'h000200, 21'h000202});
		op(16'hEF12, 11'h0);
		op(16'hF345, 11'h400);
		chk(pc_target, 21'h068A24);
		op(16'hED12, 11'h0);
		op(16'hF345, 11'h640);
		chk({pc_target, stack_push_value}, {21'h068A24, 21'h000204});
		op(16'h0C5A, 11'h180);
		wb(0, cid_pkg::OFS_WORKING, 0);
		chk(rd, 32'h5A);
		op(16'h0014, 11'h600);
		chk(pc_target[7:0], 8'h5A);
		for (int j = 0; j < 4; j++) op(16'h0010 + j[15:0], {4'h3, 1'h0, j[0], ~j[1], 4'h0});
		op(16'h0005, 11'h200);
		op(16'h0006, 11'h100);
		op(16'hF123, 11'h0);
		op(16'hCFFF, 11'h0);
		op(16'hFFFF, 11'h002);
		chk({move_src, move_dst}, {14'h0FFF, 14'h0FFF});
		wb(1, cid_pkg::OFS_BANK_SEL, 32'h05);
		op(16'h3B10, 11'h004);
		chk({indexed_mode, file_addr, file_wdata}, 23'h051035);
		op(16'h3910, 11'h0);
		wb(0, cid_pkg::OFS_WORKING, 0);
		chk(rd, 32'h35);
		op(16'h3A70, 11'h004);
		chk(file_addr, 14'h3F70);
		wb(1, cid_pkg::OFS_CTRL, 32'h01);
		wb(1, cid_pkg::OFS_INDEX_BASE, 32'h0100);
		op(16'h3A5F, 11'h004);
		chk({indexed_mode, file_addr}, 15'h415F);
		op(16'h3A60, 11'h004);
		chk(indexed_mode, 1'h0);
		// table writes in all four pointer modes
		wb(1, cid_pkg::OFS_TBL_PTR, 32'h00A356);
		ptr = 21'h00A356;
		for (int m = 0; m < 4; m++) begin
			wb(1, cid_pkg::OFS_TBL_LATCH, 32'h10 + m);
			if (m == 3) ptr++;
			idx = int'(ptr[2:0]);
			op(16'h000C + m[15:0], 11'h001);
			@(posedge ref_clk);
			#1;
			chk(hold_bytes[idx*8 +: 8], 8'h10 + m[7:0]);
			if (m == 1) ptr++;
			if (m == 2) ptr--;
			wb(0, cid_pkg::OFS_TBL_PTR, 0);
			chk(rd, {11'h0, ptr});
		end
		wb(0, cid_pkg::OFS_HOLD_LAST, 0);
		chk(rd, 32'h13);
		wb(1, 8'h40, 32'hFFFF);
		wb(0, 8'h40, 0);
		chk(rd, 32'h0);
		op(16'h0003, 11'h0);
		chk(sleep_req, 1'h1);
		op(16'h0006, 11'h0);
		@(posedge ref_clk);
		wake_evt <= 1'h1;
		@(posedge ref_clk);
		wake_evt <= 1'h0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(sleep_req, 1'h0);
		op(16'h00FF, 11'h008);
		print_verdict();
	end
endmodule
